// ### rtl/tcs_ctrl.sv
// Transceiver transmitter, fault, loss-of-signal and rate-select sideband.
//
// How it works
// RL1 - A rising laser-off request turns the laser off within 100 us.
// RL2 - After a normal laser-off release the output is back within 2 ms.
// RL3 - The management interface is ready within 300 ms of valid supply.
// RL4 - A non-cooled part reaches full operation within 300 ms of start.
// RL5 - A cooled part reaches full operation within 90 s of start.
// RL6 - Enabling power level II gives full operation within 300 ms.
// RL7 - Disabling power level II returns to level I within 300 ms.
// RL8 - A non-cooled part flags a transmitter fault within 1 ms.
// RL9 - A cooled part flags a transmitter fault within 50 ms.
// RL10 - Only a laser-off request held for 10 us clears a latched fault.
// RL11 - In Fibre Channel use rate-select changes settle within 500 us.
// RL12 - Otherwise rate-select changes settle within 10 ms.
// RL13 - Loss of signal is flagged within 100 us.
// RL14 - Return of signal clears the loss flag within 100 us.
// RL15 - A high or open laser-off request disables the laser.
// RL16 - Fault and loss flags are active high and hold while due.
`timescale 1ns/1ps
`default_nettype none
`include "tcs_regs.svh"
module tcs_ctrl #(
  parameter logic [31:0] T_ON_CYC = 32'(`TCS_CYC_MS(`TCS_T_ON_MS)),
  parameter logic [31:0] T_2W_CYC = 32'(`TCS_CYC_MS(`TCS_T_2W_MS)),
  parameter logic [31:0] T_START_CYC = 32'(`TCS_CYC_MS(`TCS_T_START_MS)),
  parameter logic [31:0] T_COOL_CYC = 32'(`TCS_CYC_S(`TCS_T_COOL_S)),
  parameter logic [31:0] T_PL2_UP_CYC = 32'(`TCS_CYC_MS(`TCS_T_PL2_UP_MS)),
  parameter logic [31:0] T_PL2_DN_CYC =
    32'(`TCS_CYC_MS(`TCS_T_PL2_DOWN_MS)),
  parameter logic [31:0] T_RS_FC_CYC = 32'(`TCS_CYC_US(`TCS_T_RS_FC_US)),
  parameter logic [31:0] T_RS_CYC = 32'(`TCS_CYC_MS(`TCS_T_RS_MS))
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic laser_off_i,
  input wire logic cooled_i,
  input wire logic supply_good_i,
  input wire logic laser_fault_i,
  input wire logic signal_present_i,
  input wire logic rate_select_high_i,
  input wire logic rate_select_low_i,
  input wire logic power_ok_i,
  input wire logic fc_mode_i,
  input wire logic pl2_request_i,
  input wire logic stop_bit_fall_i,
  output logic laser_en_o,
  output logic operational_o,
  output logic tx_fault_o,
  output logic rx_los_o,
  output logic mgmt_ready_o,
  output logic power_level2_o,
  output logic [1:0] rate_sel_o,
  output logic rate_stable_o
);
  localparam logic [`TCS_HOLD_W-1:0] HOLD_CYC =
    `TCS_HOLD_W'(`TCS_CYC_US(`TCS_T_FAULT_RESET_US));

  // --------------------------------------------------------------------
  // Reset release and pin synchronisers
  // --------------------------------------------------------------------
  logic rst_q1;
  logic rst_n;
  tcs_pkg::tcs_pins_t pins_raw;
  tcs_pkg::tcs_pins_t pins_q1;
  tcs_pkg::tcs_pins_t pins_s;

  assign pins_raw = {laser_off_i, cooled_i, supply_good_i, laser_fault_i,
                     signal_present_i, rate_select_high_i, rate_select_low_i};

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  // Reset leaves the laser-off request asserted so the laser starts dark.
  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pins_q1 <= `TCS_PINS_RST; // [RL15]
      pins_s <= `TCS_PINS_RST;
    end
    else
    begin
      pins_q1 <= pins_raw;
      pins_s <= pins_q1;
    end
  end

  // --------------------------------------------------------------------
  // Strap capture and management readiness
  // --------------------------------------------------------------------
  logic [1:0] strap_cnt;
  logic cooled;
  logic mgmt_exp;
  // The strap is taken once the synchronisers hold real pin values, and
  // no start is allowed before that, so the start limit sees the strap.
  wire strap_done = (strap_cnt == `TCS_STRAP_DONE);

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strap_cnt <= '0;
      cooled <= 1'b0;
      mgmt_ready_o <= 1'b0;
    end
    else
    begin
      if (!strap_done)
        strap_cnt <= strap_cnt + 1'b1;
      if (strap_cnt == `TCS_STRAP_TAKE)
        cooled <= pins_s.cooled;
      mgmt_ready_o <= pins_s.supply_good && mgmt_exp; // [RL3]
    end
  end

  tcs_timer u_mgmt_timer (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n),
    .clear_i(!pins_s.supply_good),
    .limit_i(T_2W_CYC),
    .expired_o(mgmt_exp)
  );

  // --------------------------------------------------------------------
  // Transmitter state machine
  // --------------------------------------------------------------------
  tcs_pkg::tcs_tx_state_t state;
  tcs_pkg::tcs_tx_state_t next_state;
  logic warm;
  logic [31:0] tx_limit;
  logic [31:0] next_limit;
  logic tx_exp;
  logic [`TCS_HOLD_W-1:0] hold_cnt;
  wire hold_done = (hold_cnt >= HOLD_CYC);
  wire pl_change = stop_bit_fall_i && (pl2_request_i != power_level2_o);
  wire [31:0] init_limit = cooled ? T_COOL_CYC : T_START_CYC; // [RL4] [RL5]
  wire [31:0] pl_limit = pl2_request_i ? T_PL2_UP_CYC : T_PL2_DN_CYC;
  wire fault_now = pins_s.laser_fault;
  wire disabled = pins_s.laser_off || !pins_s.supply_good; // [RL15]
  wire start_ok = !disabled && !tx_fault_o && strap_done;

  always_comb
  begin
    next_state = state;
    next_limit = tx_limit;
    unique case (state)
      tcs_pkg::TX_OFF:
        if (start_ok)
        begin
          next_state = tcs_pkg::TX_START;
          next_limit = warm ? T_ON_CYC : init_limit; // [RL2] [RL4] [RL5]
        end
      tcs_pkg::TX_START:
        if (fault_now || tx_exp)
          next_state = tcs_pkg::TX_FAULT; // [RL8] [RL9]
        else if (disabled)
          next_state = tcs_pkg::TX_OFF; // [RL1]
        else if (pl_change)
          next_limit = pl_limit;
        else if (power_ok_i)
          next_state = tcs_pkg::TX_ON;
      tcs_pkg::TX_ON:
        if (fault_now)
          next_state = tcs_pkg::TX_FAULT; // [RL8] [RL9]
        else if (disabled)
          next_state = tcs_pkg::TX_OFF; // [RL1]
        else if (pl_change)
        begin
          next_state = tcs_pkg::TX_START; // [RL6] [RL7]
          next_limit = pl_limit;
        end
      tcs_pkg::TX_FAULT:
        if (hold_done && pins_s.laser_off && !fault_now)
          next_state = tcs_pkg::TX_OFF; // [RL10]
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= tcs_pkg::TX_OFF;
      tx_limit <= '0;
      warm <= 1'b0;
      hold_cnt <= '0;
      laser_en_o <= 1'b0;
      operational_o <= 1'b0;
      tx_fault_o <= 1'b0;
      power_level2_o <= 1'b0;
    end
    else
    begin
      state <= next_state;
      tx_limit <= next_limit;
      if (next_state == tcs_pkg::TX_FAULT || !pins_s.supply_good)
        warm <= 1'b0;
      else if (next_state == tcs_pkg::TX_ON)
        warm <= 1'b1;
      if (state == tcs_pkg::TX_FAULT && pins_s.laser_off && !hold_done)
        hold_cnt <= hold_cnt + 1'b1; // [RL10]
      else if (!pins_s.laser_off)
        hold_cnt <= '0;
      laser_en_o <= (next_state == tcs_pkg::TX_START)
                 || (next_state == tcs_pkg::TX_ON); // [RL1] [RL15]
      operational_o <= (next_state == tcs_pkg::TX_ON);
      tx_fault_o <= (next_state == tcs_pkg::TX_FAULT); // [RL16]
      if (stop_bit_fall_i)
        power_level2_o <= pl2_request_i; // [RL6] [RL7]
    end
  end

  tcs_timer u_tx_timer (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n),
    .clear_i(state != tcs_pkg::TX_START || next_limit != tx_limit),
    .limit_i(tx_limit),
    .expired_o(tx_exp)
  );

  // --------------------------------------------------------------------
  // Receive loss flag and rate select
  // --------------------------------------------------------------------
  logic rate_exp;
  wire [1:0] rate_now = {pins_s.rate_select_high, pins_s.rate_select_low};
  wire rate_change = (rate_now != rate_sel_o);
  wire [31:0] rate_limit = fc_mode_i ? T_RS_FC_CYC : T_RS_CYC;

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_los_o <= 1'b1;
      rate_sel_o <= `TCS_RATE_RST;
      rate_stable_o <= 1'b0;
    end
    else
    begin
      rx_los_o <= !pins_s.signal_present; // [RL13] [RL14] [RL16]
      rate_sel_o <= rate_now;
      rate_stable_o <= rate_exp && !rate_change; // [RL11] [RL12]
    end
  end

  tcs_timer u_rate_timer (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n),
    .clear_i(rate_change),
    .limit_i(rate_limit),
    .expired_o(rate_exp)
  );

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n);

  laser_off_a: assert property ( // [RL1]
    pins_s.laser_off |=> !laser_en_o)
    else $error("laser still on after off request");
  warm_on_a: assert property ( // [RL2]
    (state == tcs_pkg::TX_OFF && start_ok && warm)
      |=> tx_limit == T_ON_CYC && laser_en_o)
    else $error("normal re-enable did not use short limit");
  mgmt_ready_a: assert property ( // [RL3]
    $rose(mgmt_ready_o) |-> $past(mgmt_exp) && $past(pins_s.supply_good))
    else $error("management ready too early");
  cold_limit_a: assert property ( // [RL4]
    (state == tcs_pkg::TX_OFF && start_ok && !warm && !cooled)
      |=> tx_limit == T_START_CYC)
    else $error("non-cooled start limit wrong");
  cool_limit_a: assert property ( // [RL5]
    (state == tcs_pkg::TX_OFF && start_ok && !warm && cooled)
      |=> tx_limit == T_COOL_CYC)
    else $error("cooled start limit wrong");
  start_timeout_a: assert property ( // [RL4]
    (state == tcs_pkg::TX_START && tx_exp) |=> tx_fault_o)
    else $error("start overrun not flagged");
  level_up_a: assert property ( // [RL6]
    (state == tcs_pkg::TX_ON && stop_bit_fall_i && pl2_request_i
      && !power_level2_o && !fault_now && !disabled)
      |=> power_level2_o && tx_limit == T_PL2_UP_CYC && !operational_o)
    else $error("level II entry wrong");
  level_down_a: assert property ( // [RL7]
    (stop_bit_fall_i && !pl2_request_i) |=> !power_level2_o)
    else $error("level II not dropped");
  fault_flag_a: assert property ( // [RL8] [RL9]
    (fault_now && state != tcs_pkg::TX_OFF) |=> tx_fault_o)
    else $error("fault not flagged");
  fault_clear_a: assert property ( // [RL10]
    $fell(tx_fault_o) |-> $past(hold_cnt) >= HOLD_CYC)
    else $error("fault cleared by short pulse");
  fault_hold_a: assert property ( // [RL16]
    (tx_fault_o && !pins_s.laser_off) |=> tx_fault_o)
    else $error("fault dropped without reset");
  rate_settle_a: assert property ( // [RL11] [RL12]
    rate_change |=> !rate_stable_o ##1 !rate_stable_o)
    else $error("rate marked stable during change");
  los_track_a: assert property ( // [RL13] [RL14]
    ##1 rx_los_o == !$past(pins_s.signal_present))
    else $error("loss flag does not follow signal");
endmodule // tcs_ctrl
`default_nettype wire

// ### rtl/tcs_pkg.sv
// Types shared by the sideband block.
package tcs_pkg;

  typedef struct packed {
    logic laser_off;
    logic cooled;
    logic supply_good;
    logic laser_fault;
    logic signal_present;
    logic rate_select_high;
    logic rate_select_low;
  } tcs_pins_t;

  typedef enum logic [1:0] {
    TX_OFF = 2'b00,
    TX_START = 2'b01,
    TX_ON = 2'b10,
    TX_FAULT = 2'b11
  } tcs_tx_state_t;

endpackage

// ### rtl/tcs_regs.svh
// Timing figures, derived cycle counts and reset values of the sideband block.
`ifndef TCS_REGS_SVH
`define TCS_REGS_SVH

`define TCS_MCLK_HZ 20000000

`define TCS_T_ON_MS 2
`define TCS_T_2W_MS 300
`define TCS_T_START_MS 300
`define TCS_T_COOL_S 90
`define TCS_T_PL2_UP_MS 300
`define TCS_T_PL2_DOWN_MS 300
`define TCS_T_FAULT_RESET_US 10
`define TCS_T_RS_FC_US 500
`define TCS_T_RS_MS 10

`define TCS_CYC_US(t) ((t) * (`TCS_MCLK_HZ / 1000000))
`define TCS_CYC_MS(t) ((t) * (`TCS_MCLK_HZ / 1000))
`define TCS_CYC_S(t) ((t) * `TCS_MCLK_HZ)

`define TCS_PINS_RST 7'h40
`define TCS_RATE_RST 2'h0
`define TCS_HOLD_W 8
`define TCS_STRAP_TAKE 2'h2
`define TCS_STRAP_DONE 2'h3

`endif

// ### rtl/tcs_timer.sv
// Elapsed-time counter that flags when its limit is reached.
`timescale 1ns/1ps
`default_nettype none
module tcs_timer #(
  parameter int W = 32
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic clear_i,
  input wire logic [W-1:0] limit_i,
  output logic expired_o
);
  logic [W-1:0] count;

  assign expired_o = (count >= limit_i);

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      count <= '0;
    else if (clear_i)
      count <= '0;
    else if (!expired_o)
      count <= count + 1'b1;
  end
endmodule // tcs_timer
`default_nettype wire

// ### testbench/tcs_ctrl_tb_top.sv
// Self-checking testbench of the transceiver sideband block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) \
  begin compares++; if ((a) !== (b)) begin num_errors++; \
  $display("Error t=%0t got=%h exp=%h", $time, a, b); end end
`define WAITF(c, n) \
  begin k = 0; while (!(c) && k < (n)) begin @(negedge mclk); k++; end \
  if (k >= (n)) begin num_errors++; summarize(); end end
module tcs_ctrl_tb_top;
  logic mclk = 0, rst_n = 0, laser_off = 1, supply_good = 0, fault = 0;
  logic sig = 0, rs_hi = 0, rs_lo = 0, power_ok, fc_mode = 0, pl2_req = 0;
  logic stop_fall = 0, laser_en, oper, tx_fault, rx_los, mgmt_rdy, pl2;
  logic rate_stable, cooled = 0, stall = 0;
  logic [1:0] rate_sel;
  int num_errors = 0, compares = 0, k;
  always #25 mclk = ~mclk;
  tcs_ctrl #(.T_ON_CYC(32'd60), .T_2W_CYC(32'd100), .T_START_CYC(32'd150),
    .T_RS_FC_CYC(32'd50), .T_RS_CYC(32'd120)) tcs_ctrl_inst (
    .mclk_i(mclk), .rst_n_i(rst_n), .laser_off_i(laser_off),
    .cooled_i(cooled), .supply_good_i(supply_good), .laser_fault_i(fault),
    .signal_present_i(sig), .rate_select_high_i(rs_hi),
    .rate_select_low_i(rs_lo), .power_ok_i(power_ok && !stall),
    .fc_mode_i(fc_mode),
    .pl2_request_i(pl2_req), .stop_bit_fall_i(stop_fall),
    .laser_en_o(laser_en), .operational_o(oper), .tx_fault_o(tx_fault),
    .rx_los_o(rx_los), .mgmt_ready_o(mgmt_rdy), .power_level2_o(pl2),
    .rate_sel_o(rate_sel), .rate_stable_o(rate_stable));
  tcs_power_loop tcs_power_loop_inst (
    .mclk_i(mclk), .laser_en_i(laser_en), .power_ok_o(power_ok));
  task automatic summarize();
    $display("checks=%0d errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic t_reset();
    repeat (8) @(negedge mclk);
    `CHK(rx_los, 1'b1)
    `CHK(tx_fault, 1'b0)
    `CHK(laser_en, 1'b0)
    rst_n = 1;
    repeat (4) @(negedge mclk);
    `CHK(laser_en, 1'b0)
  endtask
  task automatic t_startup();
    supply_good = 1;
    sig = 1;
    laser_off = 0;
    repeat (50) @(negedge mclk);
    `CHK(mgmt_rdy, 1'b0)
    `WAITF(mgmt_rdy, 70)
    `CHK(mgmt_rdy, 1'b1)
    `CHK(oper, 1'b1)
    `CHK(rx_los, 1'b0)
  endtask
  task automatic t_laser_off();
    laser_off = 1;
    repeat (3) @(negedge mclk);
    `CHK(laser_en, 1'b0)
    laser_off = 0;
    `WAITF(oper, 70)
    `CHK(oper, 1'b1)
  endtask
  task automatic t_fault();
    fault = 1;
    repeat (3) @(negedge mclk);
    `CHK(tx_fault, 1'b1)
    fault = 0;
    laser_off = 1;
    repeat (100) @(negedge mclk);
    laser_off = 0;
    repeat (10) @(negedge mclk);
    `CHK(tx_fault, 1'b1)
    laser_off = 1;
    repeat (190) @(negedge mclk);
    `CHK(tx_fault, 1'b1)
    `WAITF(!tx_fault, 30)
    `CHK(tx_fault, 1'b0)
    laser_off = 0;
    `WAITF(oper, 190)
    `CHK(oper, 1'b1)
  endtask
  // The power loop is held off, so a warm start overruns its limit.
  task automatic t_stall();
    stall = 1;
    laser_off = 1;
    repeat (4) @(negedge mclk);
    laser_off = 0;
    `WAITF(tx_fault, 90)
    `CHK(tx_fault, 1'b1)
    stall = 0;
    laser_off = 1;
    `WAITF(!tx_fault, 220)
    `CHK(tx_fault, 1'b0)
    laser_off = 0;
    `WAITF(oper, 190)
    `CHK(oper, 1'b1)
  endtask
  // A mid-run reset with the cooled strap set.
  task automatic t_cooled();
    rst_n = 0;
    laser_off = 1;
    cooled = 1;
    repeat (8) @(negedge mclk);
    `CHK(mgmt_rdy, 1'b0)
    `CHK(rx_los, 1'b1)
    rst_n = 1;
    repeat (4) @(negedge mclk);
    laser_off = 0;
    `WAITF(oper, 60)
    `CHK(oper, 1'b1)
    fault = 1;
    repeat (3) @(negedge mclk);
    `CHK(tx_fault, 1'b1)
  endtask
  task automatic t_los();
    sig = 0;
    repeat (3) @(negedge mclk);
    `CHK(rx_los, 1'b1)
    sig = 1;
    repeat (3) @(negedge mclk);
    `CHK(rx_los, 1'b0)
  endtask
  task automatic t_rate();
    fc_mode = 1;
    rs_lo = 1;
    repeat (4) @(negedge mclk);
    `CHK(rate_sel, 2'h1)
    `CHK(rate_stable, 1'b0)
    `WAITF(rate_stable, 60)
    `CHK(rate_stable, 1'b1)
    fc_mode = 0;
    rs_hi = 1;
    repeat (64) @(negedge mclk);
    `CHK(rate_sel, 2'h3)
    `CHK(rate_stable, 1'b0)
    `WAITF(rate_stable, 80)
    `CHK(rate_stable, 1'b1)
  endtask
  task automatic t_level(input logic req);
    pl2_req = req;
    stop_fall = 1;
    @(negedge mclk);
    stop_fall = 0;
    `CHK(pl2, req)
    `CHK(oper, 1'b0)
    `WAITF(oper, 100)
    `CHK(oper, 1'b1)
  endtask
  initial
  begin
    t_reset();
    t_startup();
    t_laser_off();
    t_fault();
    t_stall();
    t_los();
    t_rate();
    t_level(1'b1);
    t_level(1'b0);
    t_cooled();
    summarize();
  end
endmodule // tcs_ctrl_tb_top
`default_nettype wire

// ### testbench/tcs_power_loop.sv
// Model of the laser power loop that reports when output power has settled.
`timescale 1ns/1ps
`default_nettype none
module tcs_power_loop #(
  parameter int DLY = 20
) (
  input wire logic mclk_i,
  input wire logic laser_en_i,
  output logic power_ok_o
);
  int cnt = 0;
  // Power rises some cycles after enable and collapses at once on disable.
  always_ff @(posedge mclk_i)
  begin
    if (!laser_en_i)
      cnt <= 0;
    else if (cnt < DLY)
      cnt <= cnt + 1;
  end
  assign power_ok_o = laser_en_i && (cnt >= DLY);
endmodule // tcs_power_loop
`default_nettype wire
